// *** hdl/adc_regs_pkg.sv ***
package adc_regs_pkg;
    localparam logic [15:0] ADDR_CTRL1   = 16'h0001;
    localparam logic [15:0] ADDR_CTRL2   = 16'h0002;
    localparam logic [15:0] CTRL1_RESET  = 16'h001a;
    localparam logic [15:0] CTRL2_RESET  = 16'h009b;
    localparam logic [15:0] CTRL2_MASK   = 16'h002f;
    localparam int          CFG_W        = 9;
    localparam int          ACT_LO       = 9;
    localparam int          ACT_W        = 7;
    localparam int          B_DL         = 15;
    localparam int          B_RD_THR     = 14;
    localparam int          B_RD_STAT    = 11;
    localparam int          B_SYNC       = 9;
    localparam int          FLEN_HI      = 8;
    localparam int          FLEN_LO      = 5;
    localparam logic [3:0]  FLEN_DEFAULT = 4'h0;
    localparam int          B_HALF       = 5;
    localparam int          B_SLEEP      = 3;
    localparam int          B_ECON       = 2;
    localparam int          B_AMP        = 0;
    localparam int          ST_ECONOMY_MODE      = 9;
    localparam int          ST_OVR       = 8;
    localparam int          ST_DLOK      = 7;
    localparam int          ST_FOK       = 6;
    localparam int          ST_UF        = 5;
    localparam int          ST_PART_LO   = 14;
    localparam int          ST_DIE_LO    = 11;
    localparam logic [6:0]  WORDS_PER_STEP = 7'h06;
    localparam logic [6:0]  ONE_STEP     = 7'h01;

    typedef enum logic [1:0] {PH_ADDR, PH_DATA, PH_COEFF} word_phase_t;
    typedef enum logic [2:0] {
        SEL_NONE, SEL_THR, SEL_GAIN, SEL_OFF, SEL_STAT
    } read_sel_t;

    // field order matches control word bits 8..0
    typedef struct packed {
        logic [3:0] fir_length_code;
        logic       fir_stage_pass_enable;
        logic       first_stage_pass_enable;
        logic [2:0] stage2_decimation_code;
    } filter_cfg_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } reg_write_t;

    typedef struct packed {
        logic [6:0]  index;
        logic [15:0] word;
    } coeff_write_t;
endpackage

// *** hdl/coeff_download_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module coeff_download_unit
    import adc_regs_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         start_in,
    input  wire logic [3:0]   flen_in,
    input  wire logic         word_valid_in,
    input  wire logic [15:0]  word_in,
    output logic              busy_out,
    output logic              done_out,
    output logic              good_out,
    output logic              coeff_wr_valid_out,
    output adc_regs_pkg::coeff_write_t coeff_wr_out
);
    logic [6:0]  words_left_q;
    logic [6:0]  index_q;
    logic [15:0] sum_q;

    // two words per coefficient, three coefficients per length step
    function automatic logic [6:0] coeff_words(input logic [3:0] f);
        coeff_words = ({3'h0, f} + ONE_STEP) * WORDS_PER_STEP;
    endfunction

    // checksum adds each byte of every coefficient word
    function automatic logic [15:0] byte_sum(input logic [15:0] w);
        byte_sum = {8'h00, w[15:8]} + {8'h00, w[7:0]};
    endfunction

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out     <= 1'b0;
            words_left_q <= 7'h00;
            index_q      <= 7'h00;
            sum_q        <= 16'h0000;
        end else if (start_in) begin
            busy_out     <= 1'b1;
            words_left_q <= coeff_words(flen_in);
            index_q      <= 7'h00;
            sum_q        <= 16'h0000;
        end else if (busy_out && word_valid_in) begin
            if (words_left_q != 7'h00) begin
                words_left_q <= words_left_q - 7'h01;
                index_q      <= index_q + 7'h01;
                sum_q        <= sum_q + byte_sum(word_in);
            end else begin
                busy_out <= 1'b0; // checksum word closes it
            end
        end
    end

    // coefficient words go out to the filter storage
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            coeff_wr_valid_out <= 1'b0;
            coeff_wr_out       <= '0;
        end else begin
            coeff_wr_valid_out <= busy_out && word_valid_in &&
                                  (words_left_q != 7'h00);
            coeff_wr_out.index <= index_q;
            coeff_wr_out.word  <= word_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            good_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= busy_out && word_valid_in &&
                        (words_left_q == 7'h00);
            if (busy_out && word_valid_in && words_left_q == 7'h00)
                good_out <= (word_in == sum_q);
            else if (start_in)
                good_out <= 1'b0; // stale result dropped on new load
        end
    end

    a_checksum_match: assert property (
        @(posedge core_clk_in) disable iff (!rst_n_in)
        busy_out && word_valid_in && words_left_q == 7'h00
        |=> done_out && good_out == $past(word_in == sum_q))
        else $error("load good does not follow checksum");
endmodule
`default_nettype wire

// *** hdl/adc_control_register_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_bank
    import adc_regs_pkg::*;
#(
    parameter logic [1:0] PART_CODE = 2'h0, // arbitrary value
    parameter logic [2:0] DIE_CODE  = 3'h0  // arbitrary value
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         host_wr_valid_in,
    input  wire logic [15:0]  host_wr_word_in,
    input  wire logic         host_rd_req_in,
    input  wire logic [23:0]  conversion_in,
    input  wire logic [15:0]  threshold_value_in,
    input  wire logic [15:0]  gain_value_in,
    input  wire logic [15:0]  offset_value_in,
    input  wire logic [15:0]  input_level_in,
    input  wire logic         coeff_path_good_in,
    output logic              rd_valid_out,
    output logic [23:0]       rd_data_out,
    output logic              ext_wr_valid_out,
    output adc_regs_pkg::reg_write_t   ext_wr_out,
    output logic              coeff_wr_valid_out,
    output adc_regs_pkg::coeff_write_t coeff_wr_out,
    output logic              download_busy_out,
    output adc_regs_pkg::filter_cfg_t  filter_cfg_out,
    output logic              sync_start_out,
    output logic              clock_halving_select_out,
    output logic              internal_clock_tick_out,
    output logic              device_sleep_out,
    output logic              economy_mode_out,
    output logic              amp_sleep_out,
    output logic [15:0]       status_out
);
    word_phase_t phase_q;
    logic [15:0] addr_q;
    logic [ACT_W-1:0] action_q;
    read_sel_t   pend_q;
    logic [15:0] ctrl2_q;
    logic        ovr_q;
    logic        data_wr;
    logic        ctrl1_wr;
    logic        ctrl2_wr;
    logic        dl_write;
    logic        dl_done;
    logic        dl_good;
    read_sel_t   new_sel;

    // first matching select wins if the host sets several
    function automatic read_sel_t sel_decode(input logic [3:0] b);
        if (b[3])
            sel_decode = SEL_THR;
        else if (b[2])
            sel_decode = SEL_GAIN;
        else if (b[1])
            sel_decode = SEL_OFF;
        else if (b[0])
            sel_decode = SEL_STAT;
        else
            sel_decode = SEL_NONE;
    endfunction

    // decode of the data word that follows an address word
    assign data_wr  = host_wr_valid_in && (phase_q == PH_DATA);
    assign ctrl1_wr = data_wr && (addr_q == ADDR_CTRL1);
    assign ctrl2_wr = data_wr && (addr_q == ADDR_CTRL2);
    // default length code means no user filter, so no download
    assign dl_write = ctrl1_wr && host_wr_word_in[B_DL] &&
        (host_wr_word_in[FLEN_HI:FLEN_LO] != FLEN_DEFAULT);
    assign new_sel  = sel_decode(
        action_q[B_RD_THR-ACT_LO:B_RD_STAT-ACT_LO]);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= PH_ADDR;
            addr_q  <= 16'h0000;
        end else begin
            case (phase_q)
                PH_ADDR: begin
                    if (host_wr_valid_in) begin
                        addr_q  <= host_wr_word_in;
                        phase_q <= PH_DATA;
                    end
                end
                PH_DATA: begin
                    if (dl_write)
                        phase_q <= PH_COEFF;
                    else if (host_wr_valid_in)
                        phase_q <= PH_ADDR;
                end
                PH_COEFF: begin
                    if (dl_done)
                        phase_q <= PH_ADDR;
                end
                default: phase_q <= PH_ADDR;
            endcase
        end
    end

    // persistent filter configuration, bits 8..0
    // stage pass and decimation
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            filter_cfg_out <= filter_cfg_t'(CTRL1_RESET[CFG_W-1:0]);
        else if (ctrl1_wr)
            filter_cfg_out <= filter_cfg_t'(host_wr_word_in[CFG_W-1:0]);
    end

    // action bits live one cycle only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            action_q <= '0;
        else if (ctrl1_wr)
            action_q <= host_wr_word_in[15:ACT_LO];
        else
            action_q <= '0;
    end

    assign sync_start_out = action_q[B_SYNC-ACT_LO];

    // pending readback; a new select wins over a read that clears
    // select held for one read only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            pend_q <= SEL_NONE;
        else if (new_sel != SEL_NONE)
            pend_q <= new_sel;
        else if (host_rd_req_in)
            pend_q <= SEL_NONE;
    end

    // read answer one cycle after the request
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= 24'h00_0000;
        end else begin
            rd_valid_out <= host_rd_req_in;
            if (host_rd_req_in) begin
                case (pend_q)
                    SEL_THR:  rd_data_out <= {8'h00, threshold_value_in};
                    SEL_GAIN: rd_data_out <= {8'h00, gain_value_in};
                    SEL_OFF:  rd_data_out <= {8'h00, offset_value_in};
                    SEL_STAT: rd_data_out <= {8'h00, status_out};
                    default:  rd_data_out <= conversion_in;
                endcase
            end
        end
    end

    // clock and power control; writable bits only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ctrl2_q <= CTRL2_RESET;
        else if (ctrl2_wr)
            ctrl2_q <= host_wr_word_in & CTRL2_MASK;
    end

    assign device_sleep_out = ctrl2_q[B_SLEEP];
    assign economy_mode_out = ctrl2_q[B_ECON];
    assign amp_sleep_out    = ctrl2_q[B_AMP];
    assign clock_halving_select_out = ctrl2_q[B_HALF];

    // internal clock as a tick of the master clock
    // a tick, not a gated clock, keeps one clock domain
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            internal_clock_tick_out <= 1'b0;
        else if (ctrl2_q[B_HALF])
            internal_clock_tick_out <= 1'b1;
        else
            internal_clock_tick_out <= !internal_clock_tick_out;
    end

    // offset, gain and threshold writes pass to their owners
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_wr_valid_out <= 1'b0;
            ext_wr_out       <= '0;
        end else begin
            ext_wr_valid_out <= data_wr && !ctrl1_wr && !ctrl2_wr;
            ext_wr_out.addr  <= addr_q;
            ext_wr_out.data  <= host_wr_word_in;
        end
    end

    // coefficient download engine
    coeff_download_unit u_download (
        .core_clk_in        (core_clk_in),
        .rst_n_in           (rst_n_in),
        .start_in           (dl_write),
        .flen_in            (host_wr_word_in[FLEN_HI:FLEN_LO]),
        .word_valid_in      (host_wr_valid_in && phase_q == PH_COEFF),
        .word_in            (host_wr_word_in),
        .busy_out           (download_busy_out),
        .done_out           (dl_done),
        .good_out           (dl_good),
        .coeff_wr_valid_out (coeff_wr_valid_out),
        .coeff_wr_out       (coeff_wr_out)
    );

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ovr_q <= 1'b0;
        else
            ovr_q <= (input_level_in > threshold_value_in);
    end

    // status built from internal state plus the level, threshold and path good inputs, no write path
    // status assembly
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_out <= 16'h0000;
        end else begin
            status_out <= 16'h0000;
            status_out[15:ST_PART_LO]  <= PART_CODE;
            status_out[13:ST_DIE_LO]   <= DIE_CODE;
            status_out[ST_ECONOMY_MODE]        <= ctrl2_q[B_ECON];
            status_out[ST_OVR]         <= ovr_q;
            status_out[ST_DLOK]        <= dl_good;
            status_out[ST_FOK]         <= coeff_path_good_in;
            status_out[ST_UF]          <= dl_good &&
                filter_cfg_out.fir_stage_pass_enable;
            status_out[CFG_W-5:0]      <= filter_cfg_out[CFG_W-5:0];
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_action_clears: assert property (
        action_q != '0 && !ctrl1_wr |=> action_q == '0)
        else $error("action bits did not clear");

    a_download_entry: assert property (
        dl_write |=> phase_q == PH_COEFF && download_busy_out)
        else $error("download did not start");

    a_status_readback: assert property (
        host_rd_req_in && pend_q == SEL_STAT
        |=> rd_valid_out && rd_data_out[15:0] == $past(status_out))
        else $error("status readback wrong");

    a_select_consumed: assert property (
        host_rd_req_in && pend_q != SEL_NONE && new_sel == SEL_NONE
        |=> pend_q == SEL_NONE)
        else $error("select not cleared by its read");

    a_sync_pulse: assert property (
        ctrl1_wr && host_wr_word_in[B_SYNC]
        |=> sync_start_out ##1 !sync_start_out)
        else $error("sync pulse wrong");

    a_fir_bypass: assert property (
        ctrl1_wr |=> filter_cfg_out.fir_stage_pass_enable
        == $past(host_wr_word_in[4]))
        else $error("fir stage pass not taken");

    a_first_bypass: assert property (
        ctrl1_wr && !host_wr_word_in[3]
        |=> !filter_cfg_out.first_stage_pass_enable)
        else $error("first stage not bypassed");

    a_decim_code: assert property (
        ctrl1_wr |=> filter_cfg_out.stage2_decimation_code
        == $past(host_wr_word_in[2:0]))
        else $error("decimation code not taken");

    a_clock_halving: assert property (
        !ctrl2_q[B_HALF] [*2] |-> internal_clock_tick_out
        != $past(internal_clock_tick_out))
        else $error("internal clock not halved");

    a_sleep_mode: assert property (
        ctrl2_wr |=> device_sleep_out == $past(host_wr_word_in[3]))
        else $error("sleep not applied");

    a_economy_mode: assert property (
        ctrl2_wr |=> economy_mode_out == $past(host_wr_word_in[2])
        ##1 status_out[ST_ECONOMY_MODE] == economy_mode_out)
        else $error("economy mode wrong");

    a_amp_sleep: assert property (
        ctrl2_wr |=> amp_sleep_out == $past(host_wr_word_in[0]))
        else $error("amp sleep not applied");

    a_overrange: assert property (
        input_level_in > threshold_value_in |-> ##2 status_out[ST_OVR])
        else $error("overrange flag missing");

    a_status_mirror: assert property (
        ctrl1_wr ##1 !ctrl1_wr |=> status_out[4:0]
        == $past(host_wr_word_in[4:0], 2))
        else $error("status mirror wrong");

    a_status_const: assert property (
        status_out[15:ST_PART_LO] == PART_CODE && status_out[10] == 1'b0
        || !$past(rst_n_in))
        else $error("status constant bits changed");

    c_download_good: cover property (dl_done ##1 dl_good);
    c_read_status: cover property (host_rd_req_in && pend_q == SEL_STAT);
    c_sync: cover property (sync_start_out);
    c_full_rate: cover property (ctrl2_q[B_HALF] [*3]);
endmodule
`default_nettype wire

// *** test/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        clk_in,
    input  wire logic        rd_valid_in,
    input  wire logic [23:0] rd_data_in,
    output logic             wr_valid_out,
    output logic [15:0]      wr_word_out,
    output logic             rd_req_out
);
    // quiet bus at time zero
    initial begin
        wr_valid_out = 1'b0;
        wr_word_out  = 16'h0000;
        rd_req_out   = 1'b0;
    end
    // one strobe per word; a released bus shows the inverse, not a copy
    task automatic put(input logic [15:0] w);
        @(negedge clk_in);
        wr_valid_out = 1'b1;
        wr_word_out  = w;
        @(negedge clk_in);
        wr_valid_out = 1'b0;
        wr_word_out  = ~w;
    endtask
    task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
        put(a);
        put(d);
    endtask
    // answer stands only in the cycle after the request edge
    task automatic read(output logic v, output logic [23:0] d);
        @(negedge clk_in);
        rd_req_out = 1'b1;
        @(negedge clk_in);
        rd_req_out = 1'b0;
        v = rd_valid_in;
        d = rd_data_in;
    endtask
endmodule
`default_nettype wire

// *** test/tb_adc_control_register_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_register_bank;
    import adc_regs_pkg::*;
    logic         clk = 1'b0, rst_n = 1'b0, pg = 1'b1;
    logic         wv, rq, rv, xv, cv, busy, sy, hs, tk, sl, ec, am, v;
    logic [15:0]  ww, st, thr = 16'h4000, gn = 16'ha000, of = 16'h0123;
    logic [15:0]  lv = 16'h0000;
    logic [23:0]  conv = 24'h00_0000, rd, rdv;
    reg_write_t   xw;
    coeff_write_t cw_o;
    filter_cfg_t  cfg;
    logic [15:0]  got[$];
    logic [8:0]   cfg_e = 9'h01a;
    logic         econ_e = 1'b0, dlok_e = 1'b0;
    int           errors = 0, comparisons = 0, cycles = 0, n_ext = 0;
    logic [15:0]  cw [24] = '{16'h032b, 16'h9688, 16'h01bf, 16'h183c,
        16'h0015, 16'h6626, 16'h04a8, 16'h1e6a, 16'h045f, 16'h2a96,
        16'h002c, 16'h49c2, 16'h0050, 16'he9f6, 16'h0010, 16'hdbd8,
        16'h042f, 16'hde54, 16'h0437, 16'h445a, 16'h041b, 16'h7d6e,
        16'h0404, 16'h3b5f};

    always #50 clk = ~clk;

    adc_control_register_bank dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .host_wr_valid_in(wv),
        .host_wr_word_in(ww), .host_rd_req_in(rq), .conversion_in(conv),
        .threshold_value_in(thr), .gain_value_in(gn),
        .offset_value_in(of), .input_level_in(lv),
        .coeff_path_good_in(pg), .rd_valid_out(rv), .rd_data_out(rd),
        .ext_wr_valid_out(xv), .ext_wr_out(xw), .coeff_wr_valid_out(cv),
        .coeff_wr_out(cw_o), .download_busy_out(busy),
        .filter_cfg_out(cfg), .sync_start_out(sy),
        .clock_halving_select_out(hs), .internal_clock_tick_out(tk),
        .device_sleep_out(sl), .economy_mode_out(ec),
        .amp_sleep_out(am), .status_out(st));

    host_model hm (.clk_in(clk), .rd_valid_in(rv), .rd_data_in(rd),
        .wr_valid_out(wv), .wr_word_out(ww), .rd_req_out(rq));

    // capture pulses and cut a hang short
    always @(posedge clk) begin
        if (cv === 1'b1) got.push_back(cw_o.word);
        if (xv === 1'b1) n_ext++;
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] s, e, input string m);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    // status the bench expects from its own view of the state
    function automatic logic [15:0] exp_st();
        return {6'h00, econ_e, lv > thr, dlok_e, pg, dlok_e & cfg_e[4],
                cfg_e[4:0]};
    endfunction

    task automatic t_reset();
        logic a;
        check(cfg, 9'h01a, "cfg reset");
        check({hs, sl, ec, am}, 4'h5, "ctrl2 reset");
        check(st, exp_st(), "status reset");
        a = tk;
        @(negedge clk);
        check(tk, !a, "tick halved");
    endtask

    task automatic t_ctrl2();
        logic a;
        logic [15:0] w [6] = '{16'h0022, 16'h000a, 16'h0006, 16'h0003,
                               16'hffc2, 16'h0002};
        for (int i = 0; i < 6; i++) begin
            hm.write_reg(ADDR_CTRL2, w[i]);
            econ_e = w[i][2];
            @(negedge clk);
            check(hs, w[i][5], "halving");
            check(sl, w[i][3], "sleep");
            check(ec, w[i][2], "economy");
            check(am, w[i][0], "amp");
            repeat (2) @(negedge clk);
            check(st, exp_st(), "status economy");
            a = tk;
            @(negedge clk);
            check(tk, w[i][5] ? 1'b1 : !a, "tick");
        end
    endtask

    task automatic t_ctrl1();
        for (int n = 0; n < 6; n++) begin
            cfg_e = {4'h0, n[1], n[0], n[2:0]};
            hm.write_reg(ADDR_CTRL1, {7'h00, cfg_e});
            @(negedge clk);
            check(cfg, cfg_e, "cfg");
            @(negedge clk);
            check(st, exp_st(), "status mirror");
        end
        cfg_e = 9'h01a;
        hm.write_reg(ADDR_CTRL1, 16'h021a);
        // the pulse stands only in the cycle after the data edge
        check(sy, 1'b1, "sync");
        check(cfg, cfg_e, "cfg with sync");
        @(negedge clk);
        check(sy, 1'b0, "sync cleared");
    endtask

    task automatic t_readback();
        logic [23:0] e;
        for (int i = 0; i < 4; i++) begin
            hm.write_reg(ADDR_CTRL1, 16'h001a | (16'h0001 << (14 - i)));
            conv = 24'h5a_0000 + 24'(i);
            case (i)
                0: e = {8'h00, thr};
                1: e = {8'h00, gn};
                2: e = {8'h00, of};
                default: e = {8'h00, exp_st()};
            endcase
            hm.read(v, rdv);
            check(v, 1'b1, "read valid");
            check(rdv, e, "readback");
            hm.read(v, rdv);
            check(rdv, conv, "conversion");
        end
    endtask

    task automatic t_ovr();
        for (int i = 1; i >= 0; i--) begin
            @(negedge clk);
            lv = thr + 16'(i);
            pg = i[0]; // path good level follows into status
            repeat (3) @(negedge clk);
            check(st, exp_st(), "overrange");
        end
    endtask

    task automatic t_load(input logic [15:0] sum, input logic good);
        int x;
        x = n_ext;
        got.delete();
        // length set with the load request
        hm.write_reg(ADDR_CTRL1, 16'h8079);
        cfg_e = 9'h079;
        @(posedge clk);
        #1;
        check(busy, 1'b1, "busy");
        for (int k = 0; k < 24; k++) hm.put(cw[k]);
        hm.put(sum);
        dlok_e = good;
        repeat (3) @(negedge clk);
        check(busy, 1'b0, "busy end");
        check(got.size(), 24, "coeff count");
        for (int k = 0; k < 24; k++) check(got[k], cw[k], "coeff");
        check(n_ext, x, "coeff as reg");
        check(cfg, cfg_e, "cfg kept");
        check(st, exp_st(), "load good");
    endtask

    task automatic t_ext();
        hm.write_reg(ADDR_CTRL1, 16'h8019);
        cfg_e = 9'h019;
        @(posedge clk);
        #1;
        check(busy, 1'b0, "no length no load");
        hm.write_reg(16'h0005, 16'hffff);
        check(xv, 1'b1, "ext valid");
        check(xw, 32'h0005_ffff, "ext word");
        check(st, exp_st(), "status untouched");
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_ctrl2();
        t_ctrl1();
        t_readback();
        t_ovr();
        t_load(16'h0e6b, 1'b1);
        t_load(16'h0e6a, 1'b0);
        t_ext();
        stop_test();
    end
endmodule
`default_nettype wire
